// ---- rtl/nbpm_power_manager.sv ----
// notebook power manager: idle timers, drive sequencing, serial gating, thermal
//
// Summary of operation
// - several idle timers, each restarted by activity of its mapped devices
// - video timer 30s to 20min, 30min on ac; keyboard or mouse restarts
// - ports timer 30s; expiry idles pins, stops clock, drops decodes
// - disk first phase 10s to 5min, 30min on ac; spin down, interface off
// - disk second phase 10s; power off, ide clock off unless removable timer running; disk buffer already off since first phase
// - disk timer restarted by primary ide ports and alternate status
// - removable timer 30s internal floppy, else 1 to 15min, 30min on ac
// - floppy ports and secondary alternate status restart; expiry powers off, isolates drives
// - disk reset held at power-up, released before interface enable
// - optical buffer off before power removal, on after power and reset
// - optical reset asserted before power, released before buffer enable
// - shared removable power stays on while any removable drive active
// - floppy pll off only when floppy and both serial channels idle
// - serial down: decode, then tri-state and transceiver together, then clock; reverse to recover
// - infrared down: tri-state, then clock if others down; reverse to recover
// - ring indicate passes while powered down if ring resume enabled
// - parallel down is decode only; kept on for floppy via parallel
// - cpu alarm: throttle above 80c, shutdown above 95c, restore below 75c
// - full charge below 56c, trickle above 58c, shutdown above 85c
// - suspend to memory only after video, disk, removable and serial units reached low power; modem power is not checked
// - video suspend is a dedicated output; sleep is left to software
// - one modem power enable; after power-down only reinit recovers
// - disk power active high, disk reset active low
// - shared removable power driven high for on
// - removable buffer enable driven high for enabled
// - serial transceiver power-down driven high for power down
`timescale 1ns/1ps
`default_nettype none
module nbpm_power_manager #(
  parameter int TICK_CYC = nbpm_pkg::TICK_CYC,
  parameter int SEQ_CYC  = nbpm_pkg::SEQ_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       on_ac_power,
  input  wire logic [4:0] video_sel,
  input  wire logic [3:0] hdd_sel,
  input  wire logic [3:0] rmv_sel,
  input  wire logic       internal_floppy,
  input  wire logic       floppy_on_parallel,
  input  wire logic       kbd_activity,
  input  wire logic       mouse_activity,
  input  wire logic       par_activity,
  input  wire logic       first_serial_port_activity,
  input  wire logic       second_serial_port_activity,
  input  wire logic       fir_activity,
  input  wire logic       io_strobe,
  input  wire logic [9:0] io_addr,
  input  wire logic       ring_indicate_n,
  input  wire logic       resume_on_ring_en,
  input  wire logic       cpu_thermal_alarm_n,
  input  wire logic [7:0] cpu_temp,
  input  wire logic [7:0] system_thermal_sense,
  input  wire logic       modem_power_req,
  input  wire logic       modem_reinit,
  input  wire logic       suspend_req,
  output logic            video_power_down,
  output logic            hdd_power_on,
  output logic            hdd_reset_n,
  output logic            hdd_if_enable,
  output logic            hdd_spin_down,
  output logic            hdd_buffer_enable,
  output logic            ide_clock_enable,
  output logic            removable_drive_power_on,
  output logic            optical_reset_n,
  output logic            removable_buffer_enable,
  output logic            fdc_pll_enable,
  output logic            primary_uart_decode_en,
  output logic            primary_uart_out_en,
  output logic            serial_xcvr_power_down,
  output logic            ring_indicate_out_n,
  output logic            infrared_uart_out_en,
  output logic            clk14_enable,
  output logic            parallel_decode_en,
  output logic            port_pins_standby,
  output logic            cpu_throttle,
  output logic            system_shutdown,
  output logic            full_charge_en,
  output logic            trickle_charge_en,
  output logic            modem_power_enable_n,
  output logic            suspend_grant
);
  localparam int NT = 5;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pin_in;
  logic [7:0] s1;
  logic [7:0] s2;
  logic [7:0] s3;
  logic [7:0] filt;
  logic [7:0] next_filt;

  assign pin_in = {cpu_thermal_alarm_n, ring_indicate_n, fir_activity, second_serial_port_activity,
                   first_serial_port_activity, par_activity, mouse_activity, kbd_activity};

  // a change counts once the second and third stages agree
  always_comb begin
    next_filt = filt;
    for (int i = 0; i < 8; i++) begin
      if (s2[i] == s3[i]) next_filt[i] = s3[i];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1   <= nbpm_pkg::SYNC_RST;
      s2   <= nbpm_pkg::SYNC_RST;
      s3   <= nbpm_pkg::SYNC_RST;
      filt <= nbpm_pkg::SYNC_RST;
    end else begin
      s1   <= pin_in;
      s2   <= s1;
      s3   <= s2;
      filt <= next_filt;
    end
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic        tick;

  always_comb begin
    tick          = (tick_cnt == 32'(TICK_CYC - 1));
    next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) tick_cnt <= 32'h0000_0000;
    else       tick_cnt <= next_tick_cnt;
  end

  // ----------------------------------------------------------------
  // idle timers: 0 video, 1 ports, 2 disk phase 1, 3 disk phase 2, 4 removable
  // ----------------------------------------------------------------
  logic                       retrig [NT];
  logic                       run    [NT];
  logic [nbpm_pkg::TMR_W-1:0] load   [NT];
  logic                       expd   [NT];
  logic                       hdd_hit;
  logic                       rmv_hit;
  logic                       rmv_off;
  nbpm_pkg::nbpm_hdd_t        hdd_st, next_hdd_st;
  nbpm_pkg::nbpm_rmv_t        rmv_st, next_rmv_st;
  logic [15:0]                hdd_cnt, next_hdd_cnt;
  logic [15:0]                rmv_cnt, next_rmv_cnt;
  logic [1:0]                 step, next_step;
  logic                       thr, next_thr;
  logic                       full, next_full;
  logic                       lock, next_lock;
  logic [24:0]                outs, next_outs;

  nbpm_tmr_if tif [NT] ();

  for (genvar g = 0; g < NT; g++) begin : g_tmr
    nbpm_idle_timer timer_i (
      .clk  (clk),
      .rstn (rstn),
      .tick (tick),
      .t    (tif[g])
    );
    assign tif[g].retrig = retrig[g];
    assign tif[g].run    = run[g];
    assign tif[g].load   = load[g];
    assign expd[g]       = tif[g].expired;
  end

  always_comb begin
    hdd_hit   = io_strobe && nbpm_pkg::is_hdd_port(io_addr);
    rmv_hit   = io_strobe && nbpm_pkg::is_rmv_port(io_addr);
    retrig[0] = filt[0] || filt[1];
    run[0]    = 1'b1;
    load[0]   = nbpm_pkg::video_secs(video_sel, on_ac_power);
    retrig[1] = |filt[5:2];
    run[1]    = 1'b1;
    load[1]   = nbpm_pkg::PS_SECS;
    retrig[2] = hdd_hit;
    run[2]    = (hdd_st == nbpm_pkg::HDD_ON);
    load[2]   = nbpm_pkg::hdd_secs(hdd_sel, on_ac_power);
    retrig[3] = hdd_hit;
    run[3]    = (hdd_st == nbpm_pkg::HDD_STBY);
    load[3]   = nbpm_pkg::HDD2_SECS;
    retrig[4] = rmv_hit;
    run[4]    = (rmv_st == nbpm_pkg::RMV_ON);
    load[4]   = internal_floppy ? nbpm_pkg::FDD_INT_SECS :
                nbpm_pkg::rmv_secs(rmv_sel, on_ac_power);
  end

  // disk reset held while power comes up
  always_comb begin
    next_hdd_st  = hdd_st;
    next_hdd_cnt = 16'h0000;
    case (hdd_st)
      nbpm_pkg::HDD_OFF: if (hdd_hit) next_hdd_st = nbpm_pkg::HDD_PWR;
      nbpm_pkg::HDD_PWR, nbpm_pkg::HDD_RST: begin
        next_hdd_cnt = hdd_cnt + 16'h0001;
        if (hdd_cnt == 16'(SEQ_CYC - 1)) begin
          next_hdd_cnt = 16'h0000;
          if (hdd_st == nbpm_pkg::HDD_PWR) next_hdd_st = nbpm_pkg::HDD_RST;
          else next_hdd_st = nbpm_pkg::HDD_ON;
        end
      end
      nbpm_pkg::HDD_ON: if (expd[2] && !hdd_hit) next_hdd_st = nbpm_pkg::HDD_STBY;
      nbpm_pkg::HDD_STBY: begin
        if (hdd_hit) next_hdd_st = nbpm_pkg::HDD_ON;
        else if (expd[3]) next_hdd_st = nbpm_pkg::HDD_OFF;
      end
      default: next_hdd_st = nbpm_pkg::HDD_OFF;
    endcase
  end

  // reset before power, buffer last on and first off
  always_comb begin
    next_rmv_st  = rmv_st;
    next_rmv_cnt = 16'h0000;
    case (rmv_st)
      nbpm_pkg::RMV_OFF: if (rmv_hit) next_rmv_st = nbpm_pkg::RMV_PWR;
      nbpm_pkg::RMV_PWR, nbpm_pkg::RMV_RST: begin
        next_rmv_cnt = rmv_cnt + 16'h0001;
        if (rmv_cnt == 16'(SEQ_CYC - 1)) begin
          next_rmv_cnt = 16'h0000;
          if (rmv_st == nbpm_pkg::RMV_PWR) next_rmv_st = nbpm_pkg::RMV_RST;
          else next_rmv_st = nbpm_pkg::RMV_ON;
        end
      end
      nbpm_pkg::RMV_ON: if (expd[4] && !rmv_hit) next_rmv_st = nbpm_pkg::RMV_BUFOFF;
      nbpm_pkg::RMV_BUFOFF: next_rmv_st = nbpm_pkg::RMV_OFF;
      default: next_rmv_st = nbpm_pkg::RMV_OFF;
    endcase
  end

  always_comb begin
    next_step = step;
    next_thr  = thr;
    next_full = full;
    // one step a cycle, reverse on wake
    if (expd[1] && (step != 2'h3)) next_step = step + 2'h1;
    if (!expd[1] && (step != 2'h0)) next_step = step - 2'h1;
    if (!filt[7] && (cpu_temp > nbpm_pkg::CPU_THROTTLE_C)) next_thr = 1'b1;
    else if (cpu_temp < nbpm_pkg::CPU_RESTORE_C) next_thr = 1'b0;
    if (system_thermal_sense < nbpm_pkg::SYS_FULL_C) next_full = 1'b1;
    else if (system_thermal_sense > nbpm_pkg::SYS_TRICKLE_C) next_full = 1'b0;
    // a modem once down waits for reinit
    next_lock = !modem_reinit &&
                (lock || (!modem_power_enable_n && !modem_power_req));
    rmv_off   = (next_rmv_st == nbpm_pkg::RMV_OFF);
  end

  always_comb begin
    next_outs     = nbpm_pkg::OUT_RST;
    next_outs[24] = expd[0];
    // disk power high, reset low, spin and buffer
    next_outs[23] = (next_hdd_st != nbpm_pkg::HDD_OFF);
    next_outs[22] = (next_hdd_st != nbpm_pkg::HDD_OFF) &&
                    (next_hdd_st != nbpm_pkg::HDD_PWR);
    next_outs[21] = (next_hdd_st == nbpm_pkg::HDD_ON);
    next_outs[20] = (next_hdd_st == nbpm_pkg::HDD_STBY);
    next_outs[19] = (next_hdd_st == nbpm_pkg::HDD_ON);
    next_outs[18] = next_outs[21] || next_outs[20] ||
                    (next_rmv_st == nbpm_pkg::RMV_ON);
    // shared power and buffer high for on
    next_outs[17] = !rmv_off;
    next_outs[16] = !rmv_off && (next_rmv_st != nbpm_pkg::RMV_PWR);
    next_outs[15] = (next_rmv_st == nbpm_pkg::RMV_ON);
    // pll off when floppy and serial idle
    next_outs[14] = !(rmv_off && (next_step == 2'h3));
    // serial steps, ring passes if enabled
    next_outs[13] = (next_step == 2'h0);
    next_outs[12] = (next_step <= 2'h1);
    next_outs[11] = (next_step >= 2'h2);
    next_outs[10] = filt[6] || (next_outs[11] && !resume_on_ring_en);
    next_outs[9]  = next_outs[12];
    next_outs[8]  = next_outs[14];
    next_outs[7]  = !expd[1] || floppy_on_parallel;
    next_outs[6]  = expd[1];
    next_outs[5]  = next_thr;
    next_outs[4]  = (!filt[7] && (cpu_temp > nbpm_pkg::CPU_SHUTDOWN_C)) ||
                    (system_thermal_sense > nbpm_pkg::SYS_SHUTDOWN_C);
    next_outs[3]  = next_full;
    next_outs[2]  = !next_full;
    next_outs[1]  = !modem_power_req || next_lock;
    // suspend once video, disk, removable and serial units are down; modem power is not checked
    next_outs[0]  = suspend_req && !next_outs[23] && rmv_off &&
                    (next_step == 2'h3) && expd[0];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hdd_st             <= nbpm_pkg::HDD_OFF;
      rmv_st             <= nbpm_pkg::RMV_OFF;
      {hdd_cnt, rmv_cnt} <= 32'h0000_0000;
      step               <= 2'h0;
      {thr, full, lock}  <= 3'h2;
      outs               <= nbpm_pkg::OUT_RST;
    end else begin
      hdd_st             <= next_hdd_st;
      rmv_st             <= next_rmv_st;
      {hdd_cnt, rmv_cnt} <= {next_hdd_cnt, next_rmv_cnt};
      step               <= next_step;
      {thr, full, lock}  <= {next_thr, next_full, next_lock};
      outs               <= next_outs;
    end
  end

  assign {video_power_down, hdd_power_on, hdd_reset_n, hdd_if_enable, hdd_spin_down,
          hdd_buffer_enable, ide_clock_enable, removable_drive_power_on, optical_reset_n,
          removable_buffer_enable, fdc_pll_enable, primary_uart_decode_en,
          primary_uart_out_en, serial_xcvr_power_down, ring_indicate_out_n,
          infrared_uart_out_en, clk14_enable, parallel_decode_en, port_pins_standby,
          cpu_throttle, system_shutdown, full_charge_en, trickle_charge_en,
          modem_power_enable_n, suspend_grant} = outs;
endmodule
`default_nettype wire

// ---- shared/nbpm_pkg.sv ----
// constants, tables and state types of the notebook power manager
package nbpm_pkg;

  // ----------------------------------------------------------------
  // clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_HZ   = 200_000_000;
  localparam int TICK_MS  = 1000;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int SEQ_US   = 100;
  localparam int SEQ_CYC  = CLK_HZ / 1_000_000 * SEQ_US;
  localparam int TMR_W    = 11;

  // ----------------------------------------------------------------
  // fixed timeouts in seconds
  // ----------------------------------------------------------------
  localparam logic [TMR_W-1:0] PS_SECS      = 11'h01E;
  localparam logic [TMR_W-1:0] HDD2_SECS    = 11'h00A;
  localparam logic [TMR_W-1:0] FDD_INT_SECS = 11'h01E;

  // selectable timeouts in seconds, last entry allowed on ac power only
  localparam logic [TMR_W-1:0] VIDEO_SECS [18] = '{11'h01E, 11'h03C, 11'h05A, 11'h078,
    11'h096, 11'h0B4, 11'h0D2, 11'h0F0, 11'h10E, 11'h12C, 11'h168, 11'h1A4, 11'h1E0,
    11'h21C, 11'h258, 11'h384, 11'h4B0, 11'h708};
  localparam logic [TMR_W-1:0] HDD_SECS [14] = '{11'h00A, 11'h014, 11'h01E, 11'h028,
    11'h032, 11'h03C, 11'h046, 11'h050, 11'h05A, 11'h078, 11'h0B4, 11'h0F0, 11'h12C,
    11'h708};
  localparam logic [TMR_W-1:0] RMV_SECS [12] = '{11'h03C, 11'h078, 11'h0B4, 11'h0F0,
    11'h12C, 11'h168, 11'h1A4, 11'h1E0, 11'h21C, 11'h258, 11'h384, 11'h708};

  // ----------------------------------------------------------------
  // i/o ports that retrigger the drive timers
  // ----------------------------------------------------------------
  localparam logic [9:0] IO_BLK_MASK  = 10'h3F8;
  localparam logic [9:0] HDD_PRI_BASE = 10'h1F0;
  localparam logic [9:0] HDD_ALT_PORT = 10'h3F6;
  localparam logic [9:0] FDD_PORT_A   = 10'h3F2;
  localparam logic [9:0] FDD_PORT_B   = 10'h3F4;
  localparam logic [9:0] FDD_PORT_C   = 10'h3F5;
  localparam logic [9:0] FDD_PORT_D   = 10'h3F7;
  localparam logic [9:0] OPT_ALT_PORT = 10'h376;

  // ----------------------------------------------------------------
  // temperature thresholds in degrees c
  // ----------------------------------------------------------------
  localparam logic [7:0] CPU_THROTTLE_C = 8'h50;
  localparam logic [7:0] CPU_SHUTDOWN_C = 8'h5F;
  localparam logic [7:0] CPU_RESTORE_C  = 8'h4B;
  localparam logic [7:0] SYS_FULL_C     = 8'h38;
  localparam logic [7:0] SYS_TRICKLE_C  = 8'h3A;
  localparam logic [7:0] SYS_SHUTDOWN_C = 8'h55;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SYNC_RST = 8'hC0;
  localparam logic [24:0] OUT_RST = 25'h000778A;

  typedef enum logic [2:0] {HDD_OFF, HDD_PWR, HDD_RST, HDD_ON, HDD_STBY} nbpm_hdd_t;
  typedef enum logic [2:0] {RMV_OFF, RMV_PWR, RMV_RST, RMV_ON, RMV_BUFOFF} nbpm_rmv_t;

  function automatic logic [TMR_W-1:0] video_secs(logic [4:0] sel, logic ac);
    if (sel >= 5'h11) return ac ? VIDEO_SECS[17] : VIDEO_SECS[16];
    return VIDEO_SECS[sel];
  endfunction

  function automatic logic [TMR_W-1:0] hdd_secs(logic [3:0] sel, logic ac);
    if (sel >= 4'hD) return ac ? HDD_SECS[13] : HDD_SECS[12];
    return HDD_SECS[sel];
  endfunction

  function automatic logic [TMR_W-1:0] rmv_secs(logic [3:0] sel, logic ac);
    if (sel >= 4'hB) return ac ? RMV_SECS[11] : RMV_SECS[10];
    return RMV_SECS[sel];
  endfunction

  function automatic logic is_hdd_port(logic [9:0] a);
    return ((a & IO_BLK_MASK) == HDD_PRI_BASE) || (a == HDD_ALT_PORT);
  endfunction

  function automatic logic is_rmv_port(logic [9:0] a);
    return (a == FDD_PORT_A) || (a == FDD_PORT_B) || (a == FDD_PORT_C) ||
           (a == FDD_PORT_D) || (a == OPT_ALT_PORT);
  endfunction

endpackage

// ---- shared/nbpm_tmr_if.sv ----
// control bundle between the power manager and one idle timer
`timescale 1ns/1ps
`default_nettype none
interface nbpm_tmr_if;
  logic                        retrig;
  logic                        run;
  logic [nbpm_pkg::TMR_W-1:0]  load;
  logic                        expired;
  modport timer (input retrig, input run, input load, output expired);
  modport ctrl  (output retrig, output run, output load, input expired);
endinterface
`default_nettype wire

// ---- rtl/nbpm_idle_timer.sv ----
// retriggerable idle timer counting whole time-base ticks
`timescale 1ns/1ps
`default_nettype none
module nbpm_idle_timer (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         tick,
  nbpm_tmr_if.timer         t
);
  logic [nbpm_pkg::TMR_W-1:0] count;
  logic [nbpm_pkg::TMR_W-1:0] next_count;
  logic                       expired;
  logic                       next_expired;

  always_comb begin
    next_count   = count;
    next_expired = 1'b0;
    if (t.retrig || !t.run) begin
      next_count = t.load;
    end else if (tick && (count != '0)) begin
      next_count = count - 1'b1;
    end
    if (t.run && !t.retrig && (next_count == '0)) begin
      next_expired = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count   <= '0;
      expired <= 1'b0;
    end else begin
      count   <= next_count;
      expired <= next_expired;
    end
  end

  assign t.expired = expired;
endmodule
`default_nettype wire

// ---- dv/nbpm_assertions.sv ----
// port checks of the notebook power manager
`timescale 1ns/1ps
`default_nettype none
module nbpm_assertions (
  input wire logic       clk, rstn, resume_on_ring_en, ring_indicate_n, cpu_thermal_alarm_n,
  input wire logic       hdd_power_on, hdd_reset_n, hdd_if_enable, removable_drive_power_on,
  input wire logic       optical_reset_n, removable_buffer_enable, primary_uart_decode_en,
  input wire logic       primary_uart_out_en, serial_xcvr_power_down, ring_indicate_out_n,
  input wire logic       infrared_uart_out_en, clk14_enable, cpu_throttle, suspend_grant,
  input wire logic       video_power_down,
  input wire logic [7:0] cpu_temp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_hdd_if_gate: assert property (hdd_if_enable |-> hdd_power_on && hdd_reset_n)
    else $error("disk interface on too early");
  a_buf_off_first: assert property ($fell(removable_drive_power_on) |->
    !$past(removable_buffer_enable)) else $error("drive power cut with buffer on");
  a_buf_after_rst: assert property ($rose(removable_buffer_enable) |->
    removable_drive_power_on && optical_reset_n) else $error("buffer on too early");
  a_uart_order: assert property (primary_uart_decode_en |->
    primary_uart_out_en && !serial_xcvr_power_down) else $error("uart order broken");
  a_clk14_gate: assert property (!clk14_enable |-> serial_xcvr_power_down &&
    !primary_uart_out_en && !infrared_uart_out_en) else $error("clock stopped early");
  a_ring_pass: assert property ((serial_xcvr_power_down && resume_on_ring_en &&
    !ring_indicate_n) [*6] |-> !ring_indicate_out_n) else $error("ring blocked");
  a_cpu_throttle: assert property ((!cpu_thermal_alarm_n && cpu_temp > 8'h50) [*4]
    |-> ##[0:8] cpu_throttle) else $error("no throttle when hot");
  a_suspend_gate: assert property (suspend_grant |-> !hdd_power_on &&
    !removable_drive_power_on && serial_xcvr_power_down && video_power_down)
    else $error("suspend before devices idle");
  cover property ($fell(hdd_power_on));
  cover property ($rose(removable_buffer_enable));
  cover property ($rose(suspend_grant));
endmodule
bind nbpm_power_manager nbpm_assertions nbpm_assertions_i (.*);
`default_nettype wire

// ---- dv/nbpm_drive_model.sv ----
// behavioural drive behind the power, reset and buffer controls
`timescale 1ns/1ps
`default_nettype none
module nbpm_drive_model (
  input  wire logic clk,
  input  wire logic power_on,
  input  wire logic reset_n,
  input  wire logic link_en,
  output logic      ready,
  output logic      fault
);
  logic seen_rst = 1'b0;
  initial {ready, fault} = 2'b00;
  always @(posedge clk) begin
    seen_rst <= power_on && (seen_rst || !reset_n);
    ready    <= power_on && seen_rst && reset_n;
  end
  always @(posedge clk) fault <= fault || (link_en && !ready);
endmodule
`default_nettype wire

// ---- dv/test_nbpm_power_manager.sv ----
// self-checking bench of the notebook power manager
`timescale 1ns/1ps
`default_nettype none
module test_nbpm_power_manager;
  localparam int T = 4;
  int         mismatches = 0, tests_run = 0, n, k;
  logic       clk = 1'b0, rstn = 1'b0, on_ac_power = 1'b0, internal_floppy = 1'b1;
  logic       floppy_on_parallel = 1'b0, io_strobe = 1'b0, ring_indicate_n = 1'b1;
  logic       resume_on_ring_en = 1'b0, cpu_thermal_alarm_n = 1'b1, suspend_req = 1'b0;
  logic       modem_power_req = 1'b0, modem_reinit = 1'b0;
  logic [5:0] acts = 6'h00;
  logic [4:0] video_sel = 5'h00;
  logic [3:0] hdd_sel = 4'h0, rmv_sel = 4'h0;
  logic [9:0] io_addr = 10'h000, fdd_ports [4] = '{10'h3F2, 10'h3F4, 10'h3F5, 10'h3F7};
  logic [7:0] cpu_temp = 8'h30, system_thermal_sense = 8'h30;
  logic       video_power_down, hdd_power_on, hdd_reset_n, hdd_if_enable, hdd_spin_down;
  logic       hdd_buffer_enable, removable_drive_power_on, optical_reset_n, port_pins_standby;
  logic       removable_buffer_enable, primary_uart_decode_en, ring_indicate_out_n;
  logic       parallel_decode_en, cpu_throttle, system_shutdown, full_charge_en;
  logic       trickle_charge_en, modem_power_enable_n, suspend_grant, ide_clock_enable;
  logic       fdc_pll_enable, primary_uart_out_en, serial_xcvr_power_down, clk14_enable;
  logic       infrared_uart_out_en, hdd_ready, hdd_fault, rmv_ready, rmv_fault;

  nbpm_power_manager #(.TICK_CYC(T), .SEQ_CYC(4)) nbpm_power_manager_i (.*,
    .kbd_activity(acts[0]), .mouse_activity(acts[1]), .par_activity(acts[2]),
    .first_serial_port_activity(acts[3]), .second_serial_port_activity(acts[4]), .fir_activity(acts[5]));
  nbpm_drive_model nbpm_drive_model_i (.clk(clk), .power_on(hdd_power_on),
    .reset_n(hdd_reset_n), .link_en(hdd_if_enable), .ready(hdd_ready), .fault(hdd_fault));
  nbpm_drive_model opt_drive_i (.clk(clk), .power_on(removable_drive_power_on),
    .reset_n(optical_reset_n), .link_en(removable_buffer_enable), .ready(rmv_ready),
    .fault(rmv_fault));

  initial forever #2.5 clk = ~clk;
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp, input string m);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // elapsed cycles against a timeout in whole ticks
  task automatic chk_t(input int got, input int secs, input string m);
    tests_run++;
    if (got < (secs - 1) * T - 8 || got > (secs + 1) * T + 40) begin
      mismatches++;
      $display("BAD %0t %s took %0d", $time, m, got);
    end
  endtask
  task automatic upto(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic tmr(ref logic s, input logic v, input int secs, input string m);
    upto(s, v, (secs + 2) * T + 60);
    chk_t(n, secs, m);
  endtask
  task automatic act(input int i);
    @(posedge clk);
    acts <= 6'(1 << i);
    repeat (3) @(posedge clk);
    acts <= 6'h00;
  endtask
  task automatic io(input logic [9:0] a);
    @(posedge clk);
    io_addr <= a;
    io_strobe <= 1'b1;
    @(posedge clk);
    io_strobe <= 1'b0;
  endtask
  // wake, retrigger, ignore foreign ports, then both phases
  task automatic hdd_run(input logic [3:0] sel, input logic ac, input int secs);
    hdd_sel <= sel;
    on_ac_power <= ac;
    io(10'h1F0 + 10'($urandom % 8));
    upto(hdd_if_enable, 1'b1, 400);
    chk(hdd_ready, 1'b1, "disk enabled unready");
    io(10'h3F6);
    io(10'h1F8);
    io(10'h3F8);
    tmr(hdd_spin_down, 1'b1, secs, "disk first phase");
    chk(hdd_if_enable, 1'b0, "disk interface on");
    tmr(hdd_power_on, 1'b0, 10, "disk second phase");
    chk(hdd_buffer_enable, 1'b0, "disk buffer on");
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'hA28F));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    hdd_run(4'h0, 1'b0, 10);
    hdd_run(4'hD, 1'b0, 300);
    hdd_run(4'hD, 1'b1, 1800);
    k = $urandom % 9;
    hdd_run(4'(k), 1'($urandom), 10 * (k + 1));
    $display("disk test done");
    act(0);
    upto(video_power_down, 1'b0, 400);
    tmr(video_power_down, 1'b1, 30, "video timer");
    act(1);
    upto(video_power_down, 1'b0, 400);
    chk(video_power_down, 1'b0, "mouse no wake");
    video_sel <= 5'h11;
    on_ac_power <= 1'b0;
    act(0);
    upto(video_power_down, 1'b0, 400);
    tmr(video_power_down, 1'b1, 1200, "video on battery");
    $display("video test done");
    for (int i = 0; i < 2; i++) begin
      floppy_on_parallel <= i[0];
      act(2 + $urandom % 4);
      upto(port_pins_standby, 1'b0, 400);
      tmr(port_pins_standby, 1'b1, 30, "port timer");
      chk(primary_uart_decode_en, 1'b0, "uart decode on");
      chk(parallel_decode_en, i[0], "parallel decode");
    end
    resume_on_ring_en <= 1'b1;
    ring_indicate_n <= 1'b0;
    repeat (8) @(posedge clk);
    chk(ring_indicate_out_n, 1'b0, "ring lost");
    ring_indicate_n <= 1'b1;
    $display("port test done");
    io(10'h3F2);
    upto(removable_buffer_enable, 1'b1, 400);
    chk(rmv_ready, 1'b1, "drive enabled unready");
    tmr(removable_drive_power_on, 1'b0, 30, "floppy timer");
    internal_floppy <= 1'b0;
    rmv_sel <= 4'hB;
    on_ac_power <= 1'b0;
    io(10'h376);
    upto(removable_buffer_enable, 1'b1, 400);
    io(fdd_ports[$urandom % 4]);
    tmr(removable_drive_power_on, 1'b0, 900, "removable timer");
    chk(removable_buffer_enable, 1'b0, "buffer on");
    chk(hdd_fault || rmv_fault, 1'b0, "drive link early");
    $display("drive test done");
    suspend_req <= 1'b1;
    upto(suspend_grant, 1'b1, 400);
    chk(suspend_grant, 1'b1, "suspend refused");
    modem_power_req <= 1'b1;
    upto(modem_power_enable_n, 1'b0, 40);
    chk(modem_power_enable_n, 1'b0, "modem off");
    cpu_thermal_alarm_n <= 1'b0;
    cpu_temp <= 8'h51 + 8'($urandom % 14);
    upto(cpu_throttle, 1'b1, 40);
    chk(cpu_throttle, 1'b1, "no throttle");
    chk(system_shutdown, 1'b0, "early shutdown");
    cpu_temp <= 8'h4A;
    upto(cpu_throttle, 1'b0, 40);
    chk(cpu_throttle, 1'b0, "throttle stuck");
    system_thermal_sense <= 8'h37;
    upto(full_charge_en, 1'b1, 40);
    chk(full_charge_en, 1'b1, "no full charge");
    system_thermal_sense <= 8'h3B;
    upto(full_charge_en, 1'b0, 40);
    chk(trickle_charge_en, 1'b1, "no trickle");
    system_thermal_sense <= 8'h56;
    upto(system_shutdown, 1'b1, 40);
    chk(system_shutdown, 1'b1, "no shutdown");
    $display("thermal test done");
    print_verdict();
  end
endmodule
`default_nettype wire
